// [cs_pins_pkg.sv]
/*
 * Constants, register map and carrier types for the chip-select and transceiver pin block.
 * Assumes a core that presents one bus cycle at a time on the cycle struct, on the same clock.
 */
// Contract
// - Lower select low for memory references inside programmed lower region, 1K-256K.
// - Upper select low for memory references inside programmed upper block, 1K-256K.
// - Memory and peripheral selects stay driven, never floated, during bus hold.
// - Both upper and lower pins low at reset release: all pins float until reset.
// - Each of four mid selects low when its mid region is hit, 8K-512K.
// - Enhanced mode: mid select 0 is the coprocessor transfer request input.
// - Enhanced mode: mid select 3 is coprocessor select, only for coprocessor cycles.
// - Enhanced mode: mid select 1 is the coprocessor error input.
// - Peripheral selects 0-4 low on hits in I/O or memory peripheral area.
// - Sixth peripheral pin: select or latched address bit 1, held during hold.
// - Seventh peripheral pin: select or latched address bit 2, held during hold.
// - Direction low for data into device, high for device write data.
// - Direction output floats during bus hold and during reset.
// - Transceiver enable low during every memory, I/O and coprocessor access.
// - Transceiver enable high whenever direction changes level.
// - Transceiver enable high one clock after reset, then floats; floats in hold.
package cs_pins_pkg;
	localparam int AV_ADDR_W = 5;
	localparam logic [4:0] OFS_CTRL = 5'h00;
	localparam logic [4:0] OFS_LOWER_SIZE = 5'h04;
	localparam logic [4:0] OFS_UPPER_SIZE = 5'h08;
	localparam logic [4:0] OFS_MID_CFG = 5'h0c;
	localparam logic [4:0] OFS_PERIPH_BASE = 5'h10;
	localparam logic [4:0] OFS_STATUS = 5'h14;
	localparam int CTRL_ENHANCED_BIT = 0;
	localparam int CTRL_LATCH_A1_BIT = 1;
	localparam int CTRL_LATCH_A2_BIT = 2;
	localparam int CTRL_PERIPH_MEM_BIT = 3;
	localparam int MID_BASE_LSB = 0;
	localparam int MID_CODE_LSB = 8;
	localparam logic [3:0] CTRL_RESET = 4'h0;
	localparam logic [8:0] LOWER_SIZE_RESET = 9'h000;
	localparam logic [8:0] UPPER_SIZE_RESET = 9'h000;
	localparam logic [6:0] MID_BASE_RESET = 7'h00;
	localparam logic [2:0] MID_CODE_RESET = 3'h0;
	localparam logic [9:0] PERIPH_BASE_RESET = 10'h000;
	localparam int KBYTE_SHIFT = 10;
	localparam int MID_UNIT_SHIFT = 13;
	localparam int MID_BLOCK_SHIFT = 11;
	localparam int PERIPH_BLOCK_SHIFT = 7;
	localparam logic [19:0] PERIPH_SPAN = 20'h00380;
	localparam logic [2:0] SAMPLE_DELAY = 3'h4;
	typedef struct packed {
		logic active;
		logic [19:0] addr;
		logic io;
		logic write;
		logic coproc;
	} cyc_s;
	typedef struct packed {
		logic periph_mem;
		logic latch_a2;
		logic latch_a1;
		logic enhanced;
	} ctrl_s;
endpackage

// [chip_select_transceiver_pins.sv]
/*
 * Chip-select decoder and data transceiver control pins, with an Avalon-MM register slave.
 * Assumes the core holds I_CYC steady while active and drives I_HOLD while another master
 * owns the bus; pin inputs are asynchronous; two-way pins are resolved outside.
 */
`timescale 1ns/1ps
module chip_select_transceiver_pins
	import cs_pins_pkg::*;
(
	input wire logic I_REF_CLK,
	input wire logic I_RESETN,
	input wire logic [AV_ADDR_W-1:0] I_AVS_ADDRESS,
	input wire logic I_AVS_READ,
	input wire logic I_AVS_WRITE,
	input wire logic [31:0] I_AVS_WRITEDATA,
	input wire logic [3:0] I_AVS_BYTEENABLE,
	output logic [31:0] O_AVS_READDATA,
	output logic O_AVS_WAITREQUEST,
	input wire cyc_s I_CYC,
	input wire logic I_HOLD,
	input wire logic I_LOWER_MEM_SELECT_N,
	output logic O_LOWER_MEM_SELECT_N,
	output logic O_LOWER_MEM_SELECT_OE,
	input wire logic I_UPPER_MEM_SELECT_N,
	output logic O_UPPER_MEM_SELECT_N,
	output logic O_UPPER_MEM_SELECT_OE,
	input wire logic [1:0] I_MID_MEM_SELECT_N,
	output logic [3:0] O_MID_MEM_SELECT_N,
	output logic [3:0] O_MID_MEM_SELECT_OE,
	output logic [4:0] O_PERIPH_SELECT_N,
	output logic O_PERIPH_SELECT5_OR_LATCHED_ADDR1,
	output logic O_PERIPH_SELECT6_OR_LATCHED_ADDR2,
	output logic O_PERIPH_SELECT_OE,
	output logic O_XCVR_DIRECTION,
	output logic O_XCVR_DIRECTION_OE,
	output logic O_XCVR_ENABLE_N,
	output logic O_XCVR_ENABLE_OE,
	output logic O_COPROC_TRANSFER_REQUEST,
	output logic O_COPROC_ERROR,
	output logic O_TEST_MODE
);
	ctrl_s ctrl_ff;
	logic [8:0] lower_size_ff, upper_size_ff;
	logic [6:0] mid_base_ff;
	logic [2:0] mid_code_ff;
	logic [9:0] periph_base_ff;
	logic wait_ff;
	logic [3:0] s1_ff, s2_ff, s3_ff, filt_ff;
	logic [2:0] boot_cnt_ff;
	logic sample_done_ff, test_ff, first_ff, started_ff;
	logic [3:0] pins_in;

	// Avalon slave: one wait cycle, then answer
	wire req = I_AVS_READ | I_AVS_WRITE;
	wire take = req & wait_ff;
	wire csr_write = I_AVS_WRITE & ~wait_ff;
	wire [31:0] be_mask = {{8{I_AVS_BYTEENABLE[3]}}, {8{I_AVS_BYTEENABLE[2]}},
		{8{I_AVS_BYTEENABLE[1]}}, {8{I_AVS_BYTEENABLE[0]}}};
	wire wr_ctrl = csr_write & (I_AVS_ADDRESS == OFS_CTRL);
	wire wr_lower = csr_write & (I_AVS_ADDRESS == OFS_LOWER_SIZE);
	wire wr_upper = csr_write & (I_AVS_ADDRESS == OFS_UPPER_SIZE);
	wire wr_mid = csr_write & (I_AVS_ADDRESS == OFS_MID_CFG);
	wire wr_periph = csr_write & (I_AVS_ADDRESS == OFS_PERIPH_BASE);
	wire [31:0] mid_word = {21'h000000, mid_code_ff, 1'b0, mid_base_ff};
	wire [31:0] status_word = {28'h0000000, O_COPROC_ERROR, O_COPROC_TRANSFER_REQUEST,
		I_HOLD, test_ff};
	wire [31:0] cur_word = (I_AVS_ADDRESS == OFS_CTRL) ? {28'h0000000, ctrl_ff} :
		(I_AVS_ADDRESS == OFS_LOWER_SIZE) ? {23'h000000, lower_size_ff} :
		(I_AVS_ADDRESS == OFS_UPPER_SIZE) ? {23'h000000, upper_size_ff} :
		(I_AVS_ADDRESS == OFS_MID_CFG) ? mid_word :
		(I_AVS_ADDRESS == OFS_PERIPH_BASE) ? {22'h000000, periph_base_ff} :
		(I_AVS_ADDRESS == OFS_STATUS) ? status_word : 32'h00000000;
	wire [31:0] merged = (cur_word & ~be_mask) | (I_AVS_WRITEDATA & be_mask);

	always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			wait_ff <= 1'b1;
			O_AVS_WAITREQUEST <= 1'b1;
			O_AVS_READDATA <= 32'h00000000;
		end else begin
			wait_ff <= ~take;
			O_AVS_WAITREQUEST <= ~take;
			if (take && I_AVS_READ) begin
				O_AVS_READDATA <= cur_word;
			end
		end
	end

	always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			ctrl_ff <= CTRL_RESET;
			lower_size_ff <= LOWER_SIZE_RESET;
			upper_size_ff <= UPPER_SIZE_RESET;
			mid_base_ff <= MID_BASE_RESET;
			mid_code_ff <= MID_CODE_RESET;
			periph_base_ff <= PERIPH_BASE_RESET;
		end else begin
			if (wr_ctrl) ctrl_ff <= merged[3:0];
			if (wr_lower) lower_size_ff <= merged[8:0];
			if (wr_upper) upper_size_ff <= merged[8:0];
			if (wr_mid) mid_base_ff <= merged[MID_BASE_LSB +: 7];
			if (wr_mid) mid_code_ff <= merged[MID_CODE_LSB +: 3];
			if (wr_periph) periph_base_ff <= merged[9:0];
		end
	end

	// Pin input synchronisers, filtered on agreement of stages two and three
	assign pins_in = {I_MID_MEM_SELECT_N, I_UPPER_MEM_SELECT_N, I_LOWER_MEM_SELECT_N};
	generate
		for (genvar b = 0; b < 4; b++) begin : g_sync
			always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
				if (!I_RESETN) begin
					s1_ff[b] <= 1'b1;
					s2_ff[b] <= 1'b1;
					s3_ff[b] <= 1'b1;
					filt_ff[b] <= 1'b1;
				end else begin
					s1_ff[b] <= pins_in[b];
					s2_ff[b] <= s1_ff[b];
					s3_ff[b] <= s2_ff[b];
					if (s2_ff[b] == s3_ff[b]) filt_ff[b] <= s3_ff[b];
				end
			end
		end
	endgenerate

	always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			boot_cnt_ff <= 3'h0;
			sample_done_ff <= 1'b0;
			test_ff <= 1'b0;
			first_ff <= 1'b1;
		end else begin
			first_ff <= 1'b0;
			if (!sample_done_ff) boot_cnt_ff <= boot_cnt_ff + 3'h1;
			if (!sample_done_ff && boot_cnt_ff == SAMPLE_DELAY) begin
				sample_done_ff <= 1'b1;
				test_ff <= ~filt_ff[0] & ~filt_ff[1];
			end
		end
	end

	// Address decode
	wire cyc_mem = I_CYC.active & ~I_CYC.io & ~I_CYC.coproc;
	wire [9:0] kaddr = I_CYC.addr[19:KBYTE_SHIFT];
	wire lower_hit = {1'b0, kaddr} < {2'b00, lower_size_ff};
	wire upper_hit = {1'b0, ~kaddr} < {2'b00, upper_size_ff};
	wire [19:0] mid_off = I_CYC.addr - {mid_base_ff, 13'h0000};
	wire mid_hit = (mid_off >> (MID_UNIT_SHIFT + mid_code_ff)) == 20'h00000;
	wire [19:0] mid_blk = mid_off >> (MID_BLOCK_SHIFT + mid_code_ff);
	wire [1:0] mid_idx = mid_blk[1:0];
	wire periph_cyc = I_CYC.active & ~I_CYC.coproc & (ctrl_ff.periph_mem ? ~I_CYC.io : I_CYC.io);
	wire [19:0] pbase = {periph_base_ff, 10'h000};
	wire [19:0] paddr = I_CYC.io ? {4'h0, I_CYC.addr[15:0]} : I_CYC.addr;
	wire [19:0] pbase_eff = I_CYC.io ? {4'h0, pbase[15:0]} : pbase;
	wire [19:0] poff = paddr - pbase_eff;
	wire periph_hit = (paddr >= pbase_eff) & (poff < PERIPH_SPAN);
	wire [2:0] periph_idx = poff[9:7];
	wire mem_lower = cyc_mem & lower_hit;
	wire mem_upper = cyc_mem & ~lower_hit & upper_hit;
	wire mem_mid = cyc_mem & ~lower_hit & ~upper_hit & mid_hit;
	wire mem_any = mem_lower | mem_upper | mem_mid;
	wire periph_sel = periph_cyc & ~mem_any & periph_hit;

	logic [3:0] nxt_mid_n;
	logic [6:0] nxt_periph_n;
	always_comb begin
		nxt_mid_n = 4'hf;
		nxt_periph_n = 7'h7f;
		if (mem_mid) nxt_mid_n[mid_idx] = 1'b0;
		if (periph_sel) nxt_periph_n[periph_idx] = 1'b0;
		if (ctrl_ff.enhanced) nxt_mid_n[3] = ~(I_CYC.active & I_CYC.coproc);
	end

	wire drive_ok = sample_done_ff & ~test_ff;
	wire nxt_a1 = (I_CYC.active && !I_HOLD) ? I_CYC.addr[1] : O_PERIPH_SELECT5_OR_LATCHED_ADDR1;
	wire nxt_a2 = (I_CYC.active && !I_HOLD) ? I_CYC.addr[2] : O_PERIPH_SELECT6_OR_LATCHED_ADDR2;

	always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			O_LOWER_MEM_SELECT_N <= 1'b1;
			O_UPPER_MEM_SELECT_N <= 1'b1;
			O_MID_MEM_SELECT_N <= 4'hf;
			O_PERIPH_SELECT_N <= 5'h1f;
			O_PERIPH_SELECT5_OR_LATCHED_ADDR1 <= 1'b1;
			O_PERIPH_SELECT6_OR_LATCHED_ADDR2 <= 1'b1;
		end else begin
			O_LOWER_MEM_SELECT_N <= ~mem_lower;
			O_UPPER_MEM_SELECT_N <= ~mem_upper;
			O_MID_MEM_SELECT_N <= nxt_mid_n;
			O_PERIPH_SELECT_N <= nxt_periph_n[4:0];
			O_PERIPH_SELECT5_OR_LATCHED_ADDR1 <= ctrl_ff.latch_a1 ? nxt_a1 : nxt_periph_n[5];
			O_PERIPH_SELECT6_OR_LATCHED_ADDR2 <= ctrl_ff.latch_a2 ? nxt_a2 : nxt_periph_n[6];
		end
	end

	always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			O_LOWER_MEM_SELECT_OE <= 1'b0;
			O_UPPER_MEM_SELECT_OE <= 1'b0;
			O_MID_MEM_SELECT_OE <= 4'h0;
			O_PERIPH_SELECT_OE <= 1'b0;
		end else begin
			O_LOWER_MEM_SELECT_OE <= drive_ok;
			O_UPPER_MEM_SELECT_OE <= drive_ok;
			O_MID_MEM_SELECT_OE <= {drive_ok, drive_ok, {2{drive_ok & ~ctrl_ff.enhanced}}};
			O_PERIPH_SELECT_OE <= drive_ok;
		end
	end

	always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			O_COPROC_TRANSFER_REQUEST <= 1'b0;
			O_COPROC_ERROR <= 1'b0;
			O_TEST_MODE <= 1'b0;
		end else begin
			O_COPROC_TRANSFER_REQUEST <= ctrl_ff.enhanced & filt_ff[2];
			O_COPROC_ERROR <= ctrl_ff.enhanced & ~filt_ff[3];
			O_TEST_MODE <= test_ff;
		end
	end

	// Transceiver direction and enable
	wire cyc_live = I_CYC.active & ~I_HOLD;
	wire nxt_dir = (O_XCVR_ENABLE_N && cyc_live) ? I_CYC.write : O_XCVR_DIRECTION;
	wire nxt_den_n = ~(cyc_live & (I_CYC.write == O_XCVR_DIRECTION));
	wire nxt_started = started_ff | cyc_live;

	always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			O_XCVR_DIRECTION <= 1'b0;
			O_XCVR_DIRECTION_OE <= 1'b0;
			O_XCVR_ENABLE_N <= 1'b1;
			O_XCVR_ENABLE_OE <= 1'b1;
			started_ff <= 1'b0;
		end else begin
			started_ff <= nxt_started;
			O_XCVR_DIRECTION <= nxt_dir;
			O_XCVR_DIRECTION_OE <= ~test_ff & ~I_HOLD & nxt_started;
			O_XCVR_ENABLE_N <= nxt_den_n;
			// Float after one clock and in hold
			O_XCVR_ENABLE_OE <= first_ff | (~test_ff & ~I_HOLD & nxt_started);
		end
	end

	default clocking cb @(posedge I_REF_CLK); endclocking
	default disable iff (!I_RESETN);

	AST_LOWER_SEL: assert property (mem_lower |=> !O_LOWER_MEM_SELECT_N)
		else $error("lower select missed");
	AST_UPPER_SEL: assert property (mem_upper |=> !O_UPPER_MEM_SELECT_N && O_LOWER_MEM_SELECT_N)
		else $error("upper select missed");
	AST_HOLD_DRIVEN: assert property (I_HOLD && drive_ok |=> O_LOWER_MEM_SELECT_OE &&
		O_UPPER_MEM_SELECT_OE && O_PERIPH_SELECT_OE && O_MID_MEM_SELECT_OE[2])
		else $error("select floated in hold");
	AST_TEST_FLOAT: assert property (test_ff |=> !O_LOWER_MEM_SELECT_OE && !O_PERIPH_SELECT_OE &&
		O_MID_MEM_SELECT_OE == 4'h0 && !O_XCVR_ENABLE_OE && !O_XCVR_DIRECTION_OE)
		else $error("pin driven in test mode");
	AST_MID_SEL: assert property (mem_mid && mid_idx == 2'h2 |=> !O_MID_MEM_SELECT_N[2])
		else $error("mid select missed");
	AST_COPROC_SEL: assert property (ctrl_ff.enhanced && cyc_mem |=> O_MID_MEM_SELECT_N[3])
		else $error("coprocessor select on memory cycle");
	AST_PERIPH_SEL: assert property (periph_sel && periph_idx == 3'h0 |=> !O_PERIPH_SELECT_N[0])
		else $error("peripheral select missed");
	AST_A1_HOLD: assert property (I_HOLD && ctrl_ff.latch_a1 && !wr_ctrl |=>
		$stable(O_PERIPH_SELECT5_OR_LATCHED_ADDR1))
		else $error("latched address moved in hold");
	AST_A2_HOLD: assert property (I_HOLD && ctrl_ff.latch_a2 && !wr_ctrl |=>
		$stable(O_PERIPH_SELECT6_OR_LATCHED_ADDR2))
		else $error("latched address moved in hold");
	AST_DIR_FLOAT: assert property (I_HOLD |=> !O_XCVR_DIRECTION_OE)
		else $error("direction driven in hold");
	AST_DEN_ACCESS: assert property (cyc_live && I_CYC.write != O_XCVR_DIRECTION && O_XCVR_ENABLE_N |=>
		O_XCVR_DIRECTION == $past(I_CYC.write) ##1 !O_XCVR_ENABLE_N || !I_CYC.active)
		else $error("enable did not follow access");
	AST_DEN_TURN: assert property (cyc_live && I_CYC.write != O_XCVR_DIRECTION && !O_XCVR_ENABLE_N
		|=> O_XCVR_ENABLE_N && $stable(O_XCVR_DIRECTION))
		else $error("enable not dropped before turnaround");
	AST_DEN_DIR: assert property ($changed(O_XCVR_DIRECTION) |-> O_XCVR_ENABLE_N &&
		$past(O_XCVR_ENABLE_N))
		else $error("direction changed while enabled");
	AST_DEN_RESET: assert property (first_ff |-> O_XCVR_ENABLE_OE && O_XCVR_ENABLE_N ##1
		O_XCVR_ENABLE_OE && O_XCVR_ENABLE_N)
		else $error("enable not high after reset");
	AST_NO_MATCH: assert property (!I_CYC.active |=> O_LOWER_MEM_SELECT_N && O_UPPER_MEM_SELECT_N &&
		O_PERIPH_SELECT_N == 5'h1f)
		else $error("select active without cycle");
	AST_REQ_IN: assert property (ctrl_ff.enhanced && filt_ff[2] |=> O_COPROC_TRANSFER_REQUEST)
		else $error("transfer request lost");
	AST_ERR_IN: assert property (ctrl_ff.enhanced && !filt_ff[3] |=> O_COPROC_ERROR)
		else $error("coprocessor error lost");

	COV_LOWER: cover property (mem_lower ##1 !O_LOWER_MEM_SELECT_N);
	COV_DIR_TURN: cover property ($changed(O_XCVR_DIRECTION) ##1 !O_XCVR_ENABLE_N);
	COV_TEST: cover property ($rose(test_ff));
	COV_COPROC: cover property (!O_MID_MEM_SELECT_N[3] && ctrl_ff.enhanced);
endmodule

// [cs_far_side.sv]
/*
 * Far-side pin model: reset strap logic, weak pull-ups and a numerics coprocessor.
 * Assumes the bench hands it the select outputs and enables and feeds its levels back.
 */
`timescale 1ns/1ps
module cs_far_side (
	input wire logic i_strap_low,
	input wire logic i_xfer_req,
	input wire logic i_err,
	input wire logic i_lower_n,
	input wire logic i_lower_oe,
	input wire logic i_upper_n,
	input wire logic i_upper_oe,
	input wire logic [3:0] i_mid_n,
	input wire logic [3:0] i_mid_oe,
	output logic o_lower_pin,
	output logic o_upper_pin,
	output logic [1:0] o_mid_pin
);
	assign o_lower_pin = i_lower_oe ? i_lower_n : !i_strap_low;
	assign o_upper_pin = i_upper_oe ? i_upper_n : !i_strap_low;
	assign o_mid_pin[0] = i_mid_oe[0] ? i_mid_n[0] : i_xfer_req;
	assign o_mid_pin[1] = i_mid_oe[1] ? i_mid_n[1] : !i_err;
endmodule

// [chip_select_transceiver_pins_tb.sv]
/*
 * Self-checking bench: register access, decode, transceiver, hold, coprocessor, test mode.
 * Assumes the design's contract latencies and the far-side model in its own file.
 */
`timescale 1ns/1ps
module chip_select_transceiver_pins_tb;
	import cs_pins_pkg::*;
	logic I_REF_CLK, I_RESETN, I_AVS_READ, I_AVS_WRITE, I_HOLD;
	logic [AV_ADDR_W-1:0] I_AVS_ADDRESS;
	logic [31:0] I_AVS_WRITEDATA, O_AVS_READDATA, rd;
	logic [3:0] I_AVS_BYTEENABLE, O_MID_MEM_SELECT_N, O_MID_MEM_SELECT_OE;
	cyc_s I_CYC;
	logic O_AVS_WAITREQUEST, O_LOWER_MEM_SELECT_N, O_LOWER_MEM_SELECT_OE, O_UPPER_MEM_SELECT_N;
	logic O_UPPER_MEM_SELECT_OE, O_PERIPH_SELECT5_OR_LATCHED_ADDR1;
	logic O_PERIPH_SELECT6_OR_LATCHED_ADDR2, O_PERIPH_SELECT_OE, O_XCVR_DIRECTION;
	logic O_XCVR_DIRECTION_OE, O_XCVR_ENABLE_N, O_XCVR_ENABLE_OE, O_COPROC_TRANSFER_REQUEST;
	logic O_COPROC_ERROR, O_TEST_MODE, strap, xreq, err, lower_pin, upper_pin;
	logic [4:0] O_PERIPH_SELECT_N;
	logic [1:0] mid_pin;
	int n_mismatch = 0;
	int check_count = 0;

	chip_select_transceiver_pins u_dut (.*, .I_LOWER_MEM_SELECT_N(lower_pin),
		.I_UPPER_MEM_SELECT_N(upper_pin), .I_MID_MEM_SELECT_N(mid_pin));
	cs_far_side u_far (.i_strap_low(strap), .i_xfer_req(xreq), .i_err(err),
		.i_lower_n(O_LOWER_MEM_SELECT_N), .i_lower_oe(O_LOWER_MEM_SELECT_OE),
		.i_upper_n(O_UPPER_MEM_SELECT_N), .i_upper_oe(O_UPPER_MEM_SELECT_OE),
		.i_mid_n(O_MID_MEM_SELECT_N), .i_mid_oe(O_MID_MEM_SELECT_OE),
		.o_lower_pin(lower_pin), .o_upper_pin(upper_pin), .o_mid_pin(mid_pin));

	initial begin
		I_REF_CLK = 1'b0;
		forever #4 I_REF_CLK = !I_REF_CLK;
	end

	task finish_test;
		$display("mismatches %0d, checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task tick(input int n);
		repeat (n) @(posedge I_REF_CLK);
		#1;
	endtask

	task av(input logic wr, input logic [4:0] a, input logic [31:0] d);
		@(posedge I_REF_CLK);
		I_AVS_ADDRESS <= a;
		I_AVS_WRITEDATA <= d;
		I_AVS_WRITE <= wr;
		I_AVS_READ <= !wr;
		do begin
			@(posedge I_REF_CLK);
		end while (O_AVS_WAITREQUEST !== 1'b0);
		rd = O_AVS_READDATA;
		I_AVS_WRITE <= 1'b0;
		I_AVS_READ <= 1'b0;
	endtask

	task cyc(input logic [19:0] a, input logic io, input logic wr, input logic cp);
		@(posedge I_REF_CLK);
		I_CYC <= {1'b1, a, io, wr, cp};
		tick(2);
	endtask

	initial begin
		repeat (20000) @(posedge I_REF_CLK);
		n_mismatch++;
		finish_test;
	end

	initial begin
		I_RESETN = 1'b0;
		I_AVS_READ = 1'b0;
		I_AVS_WRITE = 1'b0;
		I_AVS_ADDRESS = '0;
		I_AVS_WRITEDATA = '0;
		I_AVS_BYTEENABLE = 4'hf;
		I_CYC = '0;
		I_HOLD = 1'b0;
		strap = 1'b0;
		xreq = 1'b0;
		err = 1'b0;
		tick(4);
		chk(O_XCVR_DIRECTION_OE, 1'b0);
		chk({O_XCVR_ENABLE_OE, O_XCVR_ENABLE_N}, 2'h3);
		@(posedge I_REF_CLK);
		I_RESETN <= 1'b1;
		tick(1);
		chk({O_XCVR_ENABLE_OE, O_XCVR_ENABLE_N}, 2'h3);
		tick(1);
		chk(O_XCVR_ENABLE_OE, 1'b0);
		tick(6);
		chk({O_LOWER_MEM_SELECT_OE, O_UPPER_MEM_SELECT_OE, O_TEST_MODE}, 3'h6);
		av(1'b0, OFS_CTRL, 32'h0);
		chk(rd, 32'h0);
		av(1'b1, 5'h18, 32'hffffffff);
		av(1'b0, 5'h18, 32'h0);
		chk(rd, 32'h0);
		av(1'b1, OFS_LOWER_SIZE, 32'h4);
		av(1'b1, OFS_UPPER_SIZE, 32'h2);
		av(1'b1, OFS_MID_CFG, 32'h10);
		av(1'b1, OFS_PERIPH_BASE, 32'h8);
		av(1'b0, OFS_LOWER_SIZE, 32'h0);
		chk(rd, 32'h4);
		cyc(20'h00c00, 1'b0, 1'b0, 1'b0);
		chk({O_LOWER_MEM_SELECT_N, O_UPPER_MEM_SELECT_N}, 2'h1);
		cyc(20'h01000, 1'b0, 1'b0, 1'b0);
		chk({O_LOWER_MEM_SELECT_N, O_UPPER_MEM_SELECT_N, O_MID_MEM_SELECT_N,
			O_PERIPH_SELECT_N}, 11'h7ff);
		cyc(20'hff800, 1'b0, 1'b0, 1'b0);
		chk(O_UPPER_MEM_SELECT_N, 1'b0);
		cyc(20'hff400, 1'b0, 1'b0, 1'b0);
		chk(O_UPPER_MEM_SELECT_N, 1'b1);
		for (int i = 0; i < 4; i++) begin
			cyc(20'h20000 + 20'h00800 * i, 1'b0, 1'b0, 1'b0);
			chk(O_MID_MEM_SELECT_N, 4'hf ^ (4'h1 << i));
		end
		for (int i = 0; i < 7; i++) begin
			cyc(20'h02000 + 20'h00080 * i, 1'b1, i[0], 1'b0);
			chk({O_PERIPH_SELECT6_OR_LATCHED_ADDR2, O_PERIPH_SELECT5_OR_LATCHED_ADDR1,
				O_PERIPH_SELECT_N}, 7'h7f ^ (7'h1 << i));
			tick(1);
			chk({O_XCVR_DIRECTION, O_XCVR_ENABLE_N}, {i[0], 1'b0});
		end
		av(1'b1, OFS_CTRL, 32'h8);
		cyc(20'h02080, 1'b0, 1'b0, 1'b0);
		chk(O_PERIPH_SELECT_N, 5'h1d);
		av(1'b1, OFS_CTRL, 32'h6);
		cyc(20'h00c02, 1'b0, 1'b1, 1'b0);
		chk({O_PERIPH_SELECT6_OR_LATCHED_ADDR2, O_PERIPH_SELECT5_OR_LATCHED_ADDR1}, 2'h1);
		@(posedge I_REF_CLK);
		I_HOLD <= 1'b1;
		I_CYC.addr <= 20'h00c04;
		tick(2);
		chk({O_PERIPH_SELECT6_OR_LATCHED_ADDR2, O_PERIPH_SELECT5_OR_LATCHED_ADDR1}, 2'h1);
		chk({O_LOWER_MEM_SELECT_N, O_LOWER_MEM_SELECT_OE, O_PERIPH_SELECT_OE}, 3'h3);
		chk({O_XCVR_DIRECTION_OE, O_XCVR_ENABLE_OE}, 2'h0);
		@(posedge I_REF_CLK);
		I_HOLD <= 1'b0;
		I_CYC <= '0;
		av(1'b1, OFS_CTRL, 32'h1);
		xreq <= 1'b1;
		err <= 1'b1;
		tick(8);
		chk({O_COPROC_TRANSFER_REQUEST, O_COPROC_ERROR, O_MID_MEM_SELECT_OE[1:0]}, 4'hc);
		av(1'b0, OFS_STATUS, 32'h0);
		chk(rd, 32'hc);
		cyc(20'h80000, 1'b0, 1'b1, 1'b1);
		chk({O_MID_MEM_SELECT_N[3], O_XCVR_ENABLE_N}, 2'h0);
		cyc(20'h21800, 1'b0, 1'b0, 1'b0);
		chk(O_MID_MEM_SELECT_N[3], 1'b1);
		xreq <= 1'b0;
		err <= 1'b0;
		tick(8);
		chk({O_COPROC_TRANSFER_REQUEST, O_COPROC_ERROR}, 2'h0);
		@(posedge I_REF_CLK);
		I_CYC <= '0;
		I_RESETN <= 1'b0;
		strap <= 1'b1;
		tick(5);
		@(posedge I_REF_CLK);
		I_RESETN <= 1'b1;
		tick(10);
		chk(O_TEST_MODE, 1'b1);
		chk({O_LOWER_MEM_SELECT_OE, O_UPPER_MEM_SELECT_OE, O_PERIPH_SELECT_OE,
			O_MID_MEM_SELECT_OE, O_XCVR_ENABLE_OE, O_XCVR_DIRECTION_OE}, 9'h0);
		finish_test;
	end
endmodule
